// *** core/rohc_pkg.sv ***
// Constants, field layout and carrier types of the output hold control block
package rohc_pkg;

	// Register byte offsets
	localparam logic [31:0] ENC_CTRL_OFFSET      = 32'h0000_0050;
	localparam logic [31:0] ANGLE_VIEW_OFFSET    = 32'h0000_0054;
	localparam logic [31:0] VELOCITY_VIEW_OFFSET = 32'h0000_0058;

	// Field positions of the control register
	localparam int ANGLE_HOLD_SELECT_BIT    = 29;
	localparam int VELOCITY_HOLD_SELECT_BIT = 28;
	localparam int ANGLE_HOLD_TRIGGER_BIT   = 25;
	localparam int VELOCITY_HOLD_TRIGGER_BIT = 24;
	localparam int HOLD_ON_ERROR_SELECT_BIT = 20;
	localparam int POLE_SELECT_LSB          = 16;
	localparam int POLE_SELECT_W            = 4;
	localparam int HYSTERESIS_BYPASS_BIT    = 8;
	localparam int OUTPUT_ENABLES_LSB       = 0;
	localparam int OUTPUT_ENABLES_W         = 6;

	// Angle position inside its view register
	localparam int ANGLE_VIEW_LSB = 16;

	// Reset value and mask of bits that software may change
	localparam logic [31:0] ENC_CTRL_RESET    = 32'h0000_0100;
	localparam logic [31:0] ENC_CTRL_WRITABLE = 32'h331F_013F;

	// Reset values of the held outputs
	localparam logic [31:0] HOLD_RESET = 32'h0000_0000;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_IDLE   = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_BYTE    = 3'h0;
	localparam logic [2:0] HSIZE_HALF    = 3'h1;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	// Decoded register region
	typedef enum logic [1:0] {
		RGN_NONE     = 2'b00,
		RGN_CTRL     = 2'b01,
		RGN_ANGLE    = 2'b10,
		RGN_VELOCITY = 2'b11
	} rohc_region_t;

	// Hold requests and error flag from the converter
	typedef struct packed {
		logic angle_hold_request;
		logic velocity_hold_request;
		logic error_hold_flag;
	} rohc_req_t;

	// Address phase kept for the data phase of a write
	typedef struct packed {
		logic         write;
		rohc_region_t region;
		logic [3:0]   lanes;
	} rohc_aphase_t;

endpackage

// *** core/rohc_hold_reg.sv ***
// One output register that follows, captures or freezes a live value
`timescale 1ns/1ps
module rohc_hold_reg #(
	parameter int W = 16
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] live_i,
	input  wire logic         follow_i,
	input  wire logic         capture_i,
	input  wire logic         freeze_i,
	output logic      [W-1:0] held_o
);

	logic [W-1:0] next_held;

	// Freeze wins, then live tracking, then a capture on trigger
	always_comb begin
		next_held = held_o;
		if (freeze_i) begin
			next_held = held_o;
		end else if (follow_i) begin
			next_held = live_i;
		end else if (capture_i) begin
			next_held = live_i;
		end
	end

	// Output register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			held_o <= rohc_pkg::HOLD_RESET[W-1:0];
		end else begin
			held_o <= next_held;
		end
	end

endmodule

// *** core/rohc_top.sv ***
// Output hold control register with AHB-Lite slave and the two held outputs
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module rohc_top #(
	parameter int ADDR_W  = 8,
	parameter int ANGLE_W = 16,
	parameter int VEL_W   = 32
) (
	input  wire logic                clk_i,
	input  wire logic                resetn_i,
	input  wire logic                hsel_i,
	input  wire logic [ADDR_W-1:0]   haddr_i,
	input  wire logic [1:0]          htrans_i,
	input  wire logic                hwrite_i,
	input  wire logic [2:0]          hsize_i,
	input  wire logic [31:0]         hwdata_i,
	input  wire logic                hready_i,
	output logic      [31:0]         hrdata_o,
	output logic                     hreadyout_o,
	output logic                     hresp_o,
	input  wire logic [ANGLE_W-1:0]  angle_live_i,
	input  wire logic [VEL_W-1:0]    velocity_live_i,
	input  wire rohc_pkg::rohc_req_t req_i,
	output logic      [ANGLE_W-1:0]  angle_o,
	output logic      [VEL_W-1:0]    velocity_o,
	output logic      [3:0]          pole_select_o,
	output logic                     hysteresis_bypass_select_o,
	output logic      [5:0]          output_enables_o
);

	// Refuse shapes the register map cannot hold
	generate
		if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
			$error("rohc_top: ADDR_W must lie in 8..32");
		end
		if (ANGLE_W != 16) begin : g_bad_angle
			$error("rohc_top: ANGLE_W must be 16");
		end
		if (VEL_W < 1 || VEL_W > 32) begin : g_bad_vel
			$error("rohc_top: VEL_W must lie in 1..32");
		end
	endgenerate

	// Bus state
	rohc_pkg::rohc_aphase_t aphase;
	rohc_pkg::rohc_aphase_t next_aphase;
	logic [31:0]            next_rdata;

	// Control register state
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;

	// Request edge detection state
	logic angle_req_prev;
	logic velocity_req_prev;
	logic next_angle_req_prev;
	logic next_velocity_req_prev;

	// Address phase decode
	logic                   accept;
	rohc_pkg::rohc_region_t region;
	logic [3:0]             lanes;
	logic                   size_ok;

	// Write data path
	logic [31:0] lane_mask;
	logic [31:0] write_mask;

	// Hold control terms
	logic angle_req_rise;
	logic velocity_req_rise;
	logic angle_capture;
	logic velocity_capture;
	logic error_freeze;
	logic angle_follow;
	logic velocity_follow;

	// Read views
	logic [31:0] angle_view;
	logic [31:0] velocity_view;

	// Zero-wait slave: always ready, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o     = rohc_pkg::HRESP_OKAY;

	// Transfer taken on a selected NONSEQ while the bus is ready
	assign accept = hsel_i && hready_i && (htrans_i == rohc_pkg::HTRANS_NONSEQ);

	// Region decode on the word address
	always_comb begin
		region = rohc_pkg::RGN_NONE;
		if (haddr_i[ADDR_W-1:2] == rohc_pkg::ENC_CTRL_OFFSET[ADDR_W-1:2]) begin
			region = rohc_pkg::RGN_CTRL;
		end else if (haddr_i[ADDR_W-1:2] == rohc_pkg::ANGLE_VIEW_OFFSET[ADDR_W-1:2]) begin
			region = rohc_pkg::RGN_ANGLE;
		end else if (haddr_i[ADDR_W-1:2] == rohc_pkg::VELOCITY_VIEW_OFFSET[ADDR_W-1:2]) begin
			region = rohc_pkg::RGN_VELOCITY;
		end
	end

	// Byte lanes from size and low address bits
	always_comb begin
		lanes   = 4'h0;
		size_ok = 1'b1;
		unique case (hsize_i)
			rohc_pkg::HSIZE_BYTE: begin
				lanes = 4'h1 << haddr_i[1:0];
			end
			rohc_pkg::HSIZE_HALF: begin
				lanes = haddr_i[1] ? 4'hC : 4'h3;
			end
			rohc_pkg::HSIZE_WORD: begin
				lanes = 4'hF;
			end
			default: begin
				lanes   = 4'h0;
				size_ok = 1'b0;
			end
		endcase
	end

	// Address phase capture for the following data phase
	always_comb begin
		next_aphase.write  = 1'b0;
		next_aphase.region = rohc_pkg::RGN_NONE;
		next_aphase.lanes  = 4'h0;
		if (accept && hwrite_i && size_ok) begin
			next_aphase.write  = 1'b1;
			next_aphase.region = region;
			next_aphase.lanes  = lanes;
		end
	end

	// Expand lanes to a bit mask
	always_comb begin
		lane_mask = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			lane_mask[i*8 +: 8] = {8{aphase.lanes[i]}};
		end
	end

	// Only writable bits in addressed lanes may change
	assign write_mask = lane_mask & rohc_pkg::ENC_CTRL_WRITABLE;

	// Request edges; inputs are synchronous to the clock
	assign angle_req_rise    = req_i.angle_hold_request && !angle_req_prev;
	assign velocity_req_rise = req_i.velocity_hold_request && !velocity_req_prev;

	// Control register next value
	always_comb begin
		next_ctrl = ctrl;
		// Trigger bits drop one cycle after being set
		next_ctrl[rohc_pkg::ANGLE_HOLD_TRIGGER_BIT]    = 1'b0;
		next_ctrl[rohc_pkg::VELOCITY_HOLD_TRIGGER_BIT] = 1'b0;
		if (aphase.write && aphase.region == rohc_pkg::RGN_CTRL) begin
			next_ctrl = (next_ctrl & ~write_mask) | (hwdata_i & write_mask);
			// Writing 0 to a trigger bit has no effect
			next_ctrl[rohc_pkg::ANGLE_HOLD_TRIGGER_BIT] =
				write_mask[rohc_pkg::ANGLE_HOLD_TRIGGER_BIT] &&
				hwdata_i[rohc_pkg::ANGLE_HOLD_TRIGGER_BIT];
			next_ctrl[rohc_pkg::VELOCITY_HOLD_TRIGGER_BIT] =
				write_mask[rohc_pkg::VELOCITY_HOLD_TRIGGER_BIT] &&
				hwdata_i[rohc_pkg::VELOCITY_HOLD_TRIGGER_BIT];
		end
		// Reserved bits kept at their reset value
		next_ctrl = (next_ctrl & rohc_pkg::ENC_CTRL_WRITABLE) |
			(rohc_pkg::ENC_CTRL_RESET & ~rohc_pkg::ENC_CTRL_WRITABLE);
	end

	// Edge detector history
	always_comb begin
		next_angle_req_prev    = req_i.angle_hold_request;
		next_velocity_req_prev = req_i.velocity_hold_request;
	end

	// Hold control terms from register and requests
	always_comb begin
		error_freeze     = ctrl[rohc_pkg::HOLD_ON_ERROR_SELECT_BIT] &&
			req_i.error_hold_flag;
		angle_follow     = !ctrl[rohc_pkg::ANGLE_HOLD_SELECT_BIT];
		velocity_follow  = !ctrl[rohc_pkg::VELOCITY_HOLD_SELECT_BIT];
		angle_capture    = ctrl[rohc_pkg::ANGLE_HOLD_TRIGGER_BIT] ||
			angle_req_rise;
		velocity_capture = ctrl[rohc_pkg::VELOCITY_HOLD_TRIGGER_BIT] ||
			velocity_req_rise;
	end

	// Angle held output, half a turn on the top bit
	rohc_hold_reg #(
		.W(ANGLE_W)
	) u_angle_hold (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.live_i   (angle_live_i),
		.follow_i (angle_follow),
		.capture_i(angle_capture),
		.freeze_i (error_freeze),
		.held_o   (angle_o)
	);

	// Velocity held output
	rohc_hold_reg #(
		.W(VEL_W)
	) u_velocity_hold (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.live_i   (velocity_live_i),
		.follow_i (velocity_follow),
		.capture_i(velocity_capture),
		.freeze_i (error_freeze),
		.held_o   (velocity_o)
	);

	// Read views of the held outputs
	always_comb begin
		angle_view    = 32'h0000_0000;
		velocity_view = 32'h0000_0000;
		angle_view[rohc_pkg::ANGLE_VIEW_LSB +: ANGLE_W] = angle_o;
		velocity_view[VEL_W-1:0] = velocity_o;
	end

	// Read data chosen in the address phase, newest control value
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (accept && !hwrite_i) begin
			unique case (region)
				rohc_pkg::RGN_CTRL: begin
					next_rdata = next_ctrl;
				end
				rohc_pkg::RGN_ANGLE: begin
					next_rdata = angle_view;
				end
				rohc_pkg::RGN_VELOCITY: begin
					next_rdata = velocity_view;
				end
				rohc_pkg::RGN_NONE: begin
					next_rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// Configuration fields driven out to the encoder logic
	always_comb begin
		pole_select_o = ctrl[rohc_pkg::POLE_SELECT_LSB +: rohc_pkg::POLE_SELECT_W];
		hysteresis_bypass_select_o = ctrl[rohc_pkg::HYSTERESIS_BYPASS_BIT];
		output_enables_o = ctrl[rohc_pkg::OUTPUT_ENABLES_LSB +: rohc_pkg::OUTPUT_ENABLES_W];
	end

	// Bus state registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aphase.write  <= 1'b0;
			aphase.region <= rohc_pkg::RGN_NONE;
			aphase.lanes  <= 4'h0;
			hrdata_o      <= 32'h0000_0000;
		end else begin
			aphase   <= next_aphase;
			hrdata_o <= next_rdata;
		end
	end

	// Control register and request history
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl              <= rohc_pkg::ENC_CTRL_RESET;
			angle_req_prev    <= 1'b0;
			velocity_req_prev <= 1'b0;
		end else begin
			ctrl              <= next_ctrl;
			angle_req_prev    <= next_angle_req_prev;
			velocity_req_prev <= next_velocity_req_prev;
		end
	end

endmodule

// *** sim/rohc_properties.sv ***
// Concurrent checks of the output hold control block, bound to its top
`timescale 1ns/1ps
module rohc_properties #(
	parameter int ADDR_W  = 8,
	parameter int ANGLE_W = 16,
	parameter int VEL_W   = 32
) (
	input  wire logic                clk_i,
	input  wire logic                resetn_i,
	input  wire logic                hsel_i,
	input  wire logic [ADDR_W-1:0]   haddr_i,
	input  wire logic [1:0]          htrans_i,
	input  wire logic                hwrite_i,
	input  wire logic [2:0]          hsize_i,
	input  wire logic [31:0]         hwdata_i,
	input  wire logic                hready_i,
	input  wire logic [31:0]         hrdata_o,
	input  wire logic                hreadyout_o,
	input  wire logic                hresp_o,
	input  wire logic [ANGLE_W-1:0]  angle_live_i,
	input  wire logic [VEL_W-1:0]    velocity_live_i,
	input  wire rohc_pkg::rohc_req_t req_i,
	input  wire logic [ANGLE_W-1:0]  angle_o,
	input  wire logic [VEL_W-1:0]    velocity_o
);
	logic [3:0] wp;
	logic       sa, sv, se, ta, tv;
	// Accepted transfer, word index, byte lanes and error freeze
	wire        tk = hsel_i && hready_i && htrans_i == rohc_pkg::HTRANS_NONSEQ;
	wire [5:0]  wa = haddr_i[7:2];
	wire [3:0]  ln = hsize_i == 3'h2 ? 4'hF : (hsize_i == 3'h1 ? 4'h3 : 4'h1) << haddr_i[1:0];
	wire        fz = se && req_i.error_hold_flag;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Shadow of select and trigger bits, taken in the write data phase
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			{wp, sa, sv, se, ta, tv} <= '0;
		end else begin
			wp <= tk && hwrite_i && wa == 6'h14 ? ln : 4'h0;
			ta <= wp[3] && hwdata_i[25];
			tv <= wp[3] && hwdata_i[24];
			if (wp[3]) {sa, sv} <= hwdata_i[29:28];
			if (wp[2]) se <= hwdata_i[20];
		end
	end
	property p_okay; hreadyout_o && hresp_o == rohc_pkg::HRESP_OKAY; endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready");
	property p_fol_a; !sa && !fz |=> angle_o == $past(angle_live_i); endproperty
	a_fol_a: assert property (p_fol_a) else $error("angle not live");
	property p_fol_v; !sv && !fz |=> velocity_o == $past(velocity_live_i); endproperty
	a_fol_v: assert property (p_fol_v) else $error("velocity not live");
	property p_cap_a;
		(ta || $rose(req_i.angle_hold_request)) && !fz |=> angle_o == $past(angle_live_i);
	endproperty
	a_cap_a: assert property (p_cap_a) else $error("angle not captured");
	property p_cap_v;
		(tv || $rose(req_i.velocity_hold_request)) && !fz |=> velocity_o == $past(velocity_live_i);
	endproperty
	a_cap_v: assert property (p_cap_v) else $error("velocity not captured");
	property p_keep_a;
		sa && !ta && !$rose(req_i.angle_hold_request) && !fz |=> $stable(angle_o);
	endproperty
	a_keep_a: assert property (p_keep_a) else $error("held angle moved");
	property p_frz; fz |=> $stable(angle_o) && $stable(velocity_o); endproperty
	a_frz: assert property (p_frz) else $error("error freeze broken");
	property p_view;
		tk && !hwrite_i && wa == 6'h15 |=> hrdata_o == {$past(angle_o), 16'h0000};
	endproperty
	a_view: assert property (p_view) else $error("angle view wrong");
	property p_resv;
		tk && !hwrite_i && wa == 6'h14 |=> (hrdata_o & ~rohc_pkg::ENC_CTRL_WRITABLE) == 0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bit set");
	// Main scenarios reached
	c_sw: cover property (ta && tv);
	c_hw: cover property ($rose(req_i.angle_hold_request) && sa);
	c_frz: cover property (fz);
endmodule

bind rohc_top rohc_properties #(.ADDR_W(ADDR_W), .ANGLE_W(ANGLE_W), .VEL_W(VEL_W)) i_rohc_properties (
	.clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
	.hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .angle_live_i, .velocity_live_i,
	.req_i, .angle_o, .velocity_o
);

// *** sim/rohc_tb_top.sv ***
// Self-checking testbench of the output hold control block
`timescale 1ns/1ps
module rohc_tb_top;
	logic                clk_i, resetn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
	logic [7:0]          haddr_i;
	logic [1:0]          htrans_i;
	logic [2:0]          hsize_i;
	logic [31:0]         hwdata_i, hrdata_o, rv, e, velocity_live_i, velocity_o;
	logic [15:0]         angle_live_i, angle_o;
	logic [3:0]          pole_select_o;
	logic                hysteresis_bypass_select_o;
	logic [5:0]          output_enables_o;
	rohc_pkg::rohc_req_t req_i;
	int                  fail_count, samples_checked;

	rohc_top i_rohc_top (
		.clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
		.hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .angle_live_i,
		.velocity_live_i, .req_i, .angle_o, .velocity_o, .pole_select_o,
		.hysteresis_bypass_select_o, .output_enables_o
	);

	// Clock at 200 MHz
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Compare seen against expected
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			fail_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, s, x);
		end
	endtask

	// Bounded wait for hready at a rising edge
	task automatic hw;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 16) begin
				fail_count++;
				finish_test;
			end
		end while (hreadyout_o !== 1'b1);
	endtask

	// One single AHB-Lite transfer; read data lands in rv
	task automatic xf(input logic w, input logic [7:0] a, input logic [2:0] z,
			input logic [31:0] d);
		hsel_i   <= 1'b1;
		htrans_i <= rohc_pkg::HTRANS_NONSEQ;
		haddr_i  <= a;
		hwrite_i <= w;
		hsize_i  <= z;
		hw();
		hsel_i   <= 1'b0;
		htrans_i <= rohc_pkg::HTRANS_IDLE;
		hwdata_i <= d;
		hw();
		rv = hrdata_o;
	endtask

	// Drive requests and live values, then let them settle
	task automatic st(input logic [2:0] r, input logic [15:0] a, input logic [31:0] v);
		@(posedge clk_i);
		req_i           <= r;
		angle_live_i    <= a;
		velocity_live_i <= v;
		repeat (3) @(posedge clk_i);
		#1;
	endtask

	// Main sequence
	initial begin
		{resetn_i, hsel_i, hwrite_i, haddr_i, htrans_i, hsize_i, hwdata_i} = '0;
		angle_live_i = 16'h1111;
		velocity_live_i = 32'h0000_2222;
		req_i = '0;
		repeat (4) @(posedge clk_i);
		resetn_i <= 1'b1;
		xf(0, 8'h50, 3'h2, 0);
		chk(rv, 32'h0000_0100);
		chk(hysteresis_bypass_select_o, 1'b1);
		e = 32'h301F_013F;
		xf(1, 8'h50, 3'h2, e);
		xf(0, 8'h50, 3'h2, 0);
		chk(rv, e);
		chk(output_enables_o, 6'h3F);
		for (int n = 0; n < 4; n++) begin
			e[8*n +: 8] = 8'h00;
			xf(1, 8'h50 | 8'(n), 3'h0, ~e & 32'h331F_013F & ~(32'h0000_00FF << 8 * n));
			xf(0, 8'h50, 3'h2, 0);
			chk(rv, e);
		end
		xf(1, 8'h52, 3'h1, 32'h301F_0000);
		xf(0, 8'h50, 3'h2, 0);
		chk(rv, 32'h301F_0000);
		chk(pole_select_o, 4'hF);
		xf(0, 8'h5C, 3'h2, 0);
		chk(rv, 0);
		xf(1, 8'h50, 3'h2, 32'h0000_0100);
		xf(1, 8'h54, 3'h2, 32'hFFFF_FFFF);
		xf(0, 8'h50, 3'h2, 0);
		chk(rv, 32'h0000_0100);
		st(3'b000, 16'h1234, 32'h0001_5678);
		chk(angle_o, 16'h1234);
		chk(velocity_o, 32'h0001_5678);
		xf(1, 8'h50, 3'h2, 32'h3000_0100);
		st(3'b000, 16'h4321, 32'h0008_7654);
		chk(angle_o, 16'h1234);
		chk(velocity_o, 32'h0001_5678);
		xf(0, 8'h54, 3'h2, 0);
		chk(rv, 32'h1234_0000);
		xf(1, 8'h50, 3'h2, 32'h3300_0100);
		@(posedge clk_i);
		xf(0, 8'h50, 3'h2, 0);
		chk(rv, 32'h3000_0100);
		chk(angle_o, 16'h4321);
		chk(velocity_o, 32'h0008_7654);
		st(3'b100, 16'h0AAA, 32'h0000_0BBB);
		chk(angle_o, 16'h0AAA);
		chk(velocity_o, 32'h0008_7654);
		st(3'b010, 16'h0CCC, 32'h0000_0DDD);
		chk(angle_o, 16'h0AAA);
		chk(velocity_o, 32'h0000_0DDD);
		xf(1, 8'h50, 3'h2, 32'h0010_0100);
		st(3'b001, 16'h0EEE, 32'h0000_0FFF);
		chk(angle_o, 16'h0CCC);
		chk(velocity_o, 32'h0000_0DDD);
		st(3'b000, 16'h0EEE, 32'h0000_0FFF);
		chk(angle_o, 16'h0EEE);
		xf(0, 8'h58, 3'h2, 0);
		chk(rv, 32'h0000_0FFF);
		finish_test;
	end
endmodule
